// File: pkg/psl_regs.vh
// Constants for the strap latch and MII pin block
`ifndef PSL_REGS_VH
`define PSL_REGS_VH

`define PSL_CLK_HZ 40000000
`define PSL_SYNC_STAGES 3
`define PSL_SETTLE_CYC 3'h3

`define PSL_NPINS 10
`define PSL_PIN_ADDR0 0
`define PSL_PIN_ADDR1 1
`define PSL_PIN_ADDR2 2
`define PSL_PIN_BCAST 3
`define PSL_PIN_MODE0 4
`define PSL_PIN_MODE1 5
`define PSL_PIN_MODE2 6
`define PSL_PIN_ISO 7
`define PSL_PIN_SPEED 8
`define PSL_PIN_DUPLEX 9

`define PSL_PU_MASK 10'h301
`define PSL_PD_MASK 10'h0FE
`define PSL_KEEP_PU_MASK 10'h000

`define PSL_OFF_CTRL 4'h0
`define PSL_OFF_ADV 4'h4
`define PSL_OFF_STRAP 4'h8
`define PSL_OFF_MODE 4'hC

`define PSL_CTRL_DUPLEX 8
`define PSL_CTRL_ISO 10
`define PSL_CTRL_SPEED 13
`define PSL_CTRL_WMASK 32'h00002500
`define PSL_CTRL_RST 32'h00002100

`define PSL_ADV_10HD 5
`define PSL_ADV_10FD 6
`define PSL_ADV_100HD 7
`define PSL_ADV_100FD 8
`define PSL_ADV_WMASK 32'h000001E0
`define PSL_ADV_RST 32'h000001E0
`define PSL_ADV_10ONLY 32'h00000060

`define PSL_STRAP_DONE 16
`define PSL_MODE_MII 3'h0
`define PSL_MODE_B2B 3'h6

`endif

// File: core/psl_sync.v
// Three-stage synchroniser with agreement flag for pin inputs
`timescale 1ns/1ps
module psl_sync #(
    parameter W = 10
) (
    input wire i_clk,
    input wire [W-1:0] i_d,
    output wire [W-1:0] o_q,
    output wire o_agree
);
    // No reset: these flops only follow the pins
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;

    always @(posedge i_clk)
    begin
        s1_r <= i_d;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    assign o_q = s3_r;
    assign o_agree = (s2_r == s3_r);
endmodule // psl_sync

// File: core/psl_mii.v
// MII nibble path: receive drive and transmit capture on a derived MII clock
`timescale 1ns/1ps
module psl_mii (
    input wire i_clk,
    input wire i_rstn,
    input wire [3:0] i_rx_nib,
    input wire i_rx_valid,
    output wire o_rx_taken,
    output reg [3:0] o_mii_rxd,
    output reg o_mii_rxdv,
    output reg o_mii_clk,
    input wire [3:0] i_mii_txd,
    input wire i_mii_txen,
    output reg [3:0] o_tx_nib,
    output reg o_tx_valid
);
    // MII clock is i_clk divided by two; rx data changes on its falling edge
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_mii_clk <= 1'b0;
            o_mii_rxd <= 4'h0;
            o_mii_rxdv <= 1'b0;
            o_tx_nib <= 4'h0;
            o_tx_valid <= 1'b0;
        end
        else
        begin
            o_mii_clk <= ~o_mii_clk;
            o_tx_valid <= 1'b0;
            if (o_mii_clk)
            begin
                o_mii_rxdv <= i_rx_valid;
                o_mii_rxd <= i_rx_valid ? i_rx_nib : 4'h0;
            end
            else if (i_mii_txen)
            begin
                // Sampled at the rising MII clock edge, MAC drove after the last one
                o_tx_nib <= i_mii_txd;
                o_tx_valid <= 1'b1;
            end
        end
    end

    assign o_rx_taken = o_mii_clk;
endmodule // psl_mii

// File: core/psl_top.v
// Strap latch at reset release, shared pin control, config registers and MII
//
// Overview of operation
// - i_rstn is active low, holds the block in reset while low and lets it run when high.
// - Strap pins are inputs with their pull during reset and until the straps are latched, then become driven outputs.
// - A pin with a kept pull-up keeps that pull-up on while it drives after reset.
// - The receive nibble is launched on the MII clock handed to the MAC.
// - The receive nibble is valid only while receive-valid is high, and is zeroed otherwise.
// - The transmit nibble is taken only while transmit-enable is high and ignored otherwise.
// - The three address straps form the management address, default one.
// - Address zero is this block's own unique address only if broadcast-off was high.
// - Mode straps give plain MII for 000, back-to-back for 110, others reserved.
// - The isolate strap is copied into control bit 10, high meaning isolate.
// - The speed strap is copied into control bit 13, high meaning 100 Mbps.
// - The speed strap also sets the speed abilities in the advertisement word.
// - The duplex strap is copied into control bit 8, high meaning half duplex.
// - With broadcast-off low, address zero is answered as well as the own address.
`timescale 1ns/1ps
`include "psl_regs.vh"
module psl_top #(
    parameter [9:0] KEEP_PU_MASK = `PSL_KEEP_PU_MASK
) (
    input wire i_clk,
    input wire i_rstn,
    input wire [9:0] i_strap_pin_in,
    input wire [9:0] i_strap_pin_func,
    output reg [9:0] o_strap_pin_out,
    output reg [9:0] o_strap_pin_oe_n,
    output reg [9:0] o_strap_pin_pu,
    output reg [9:0] o_strap_pin_pd,
    output reg o_straps_done,
    output reg [4:0] o_mgmt_addr,
    output reg o_bcast_zero_en,
    input wire [4:0] i_mgmt_req_addr,
    output wire o_mgmt_addr_hit,
    output reg o_mode_mii,
    output reg o_mode_b2b,
    output reg o_mode_reserved,
    output wire o_isolate,
    output wire o_speed100,
    output wire o_duplex_half,
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    input wire [3:0] i_rx_nib,
    input wire i_rx_valid,
    output wire o_rx_taken,
    output wire [3:0] o_mii_rxd,
    output wire o_mii_rxdv,
    output wire o_mii_rxc,
    output wire o_mii_txc,
    input wire [3:0] i_mii_txd,
    input wire i_mii_txen,
    output wire [3:0] o_tx_nib,
    output wire o_tx_valid
);
    localparam [2:0] ST_SETTLE = 3'h1;
    localparam [2:0] ST_SAMPLE = 3'h2;
    localparam [2:0] ST_RUN = 3'h4;

    // Merge write data into a register under byte enables and a write mask
    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] wdata;
        input [3:0] be;
        input [31:0] wmask;
        reg [31:0] lanes;
        begin
            lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
            be_merge = (old & ~(lanes & wmask)) | (wdata & lanes & wmask);
        end
    endfunction

    // Advertisement word from the speed strap
    function [31:0] adv_from_speed;
        input speed;
        begin
            adv_from_speed = speed ? `PSL_ADV_RST : `PSL_ADV_10ONLY;
        end
    endfunction

    // Mode strap pattern to {reserved, back-to-back, plain MII}
    function [2:0] mode_class;
        input [2:0] code;
        begin
            if (code == `PSL_MODE_MII)
                mode_class = 3'h1;
            else if (code == `PSL_MODE_B2B)
                mode_class = 3'h2;
            else
                mode_class = 3'h4;
        end
    endfunction

    // Management address from the strap image; the upper two bits stay zero
    function [4:0] mgmt_from_straps;
        input [9:0] straps;
        begin
            mgmt_from_straps = {2'h0, straps[`PSL_PIN_ADDR2], straps[`PSL_PIN_ADDR1],
                straps[`PSL_PIN_ADDR0]};
        end
    endfunction

    // Register offset to a one-hot select: {mode, strap, adv, ctrl}
    function [3:0] reg_sel;
        input [3:0] addr;
        begin
            case (addr)
                `PSL_OFF_CTRL: reg_sel = 4'h1;
                `PSL_OFF_ADV: reg_sel = 4'h2;
                `PSL_OFF_STRAP: reg_sel = 4'h4;
                `PSL_OFF_MODE: reg_sel = 4'h8;
                default: reg_sel = 4'h0;
            endcase
        end
    endfunction

    wire [9:0] pin_sync;
    wire pin_agree;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [2:0] settle_r;
    reg [9:0] strap_r;
    reg [31:0] ctrl_r;
    reg [31:0] adv_r;
    reg ack_r;
    wire bus_req;
    wire bus_wr;
    wire capture;
    wire [2:0] mode_code;
    wire mii_clk;
    wire [3:0] rsel;
    wire wr_ctrl;
    wire wr_adv;
    reg [31:0] rdata_nxt;
    wire cap_speed;
    wire cap_iso;
    wire cap_duplex;

    psl_sync #(
        .W(`PSL_NPINS)
    ) u_sync (
        .i_clk(i_clk),
        .i_d(i_strap_pin_in),
        .o_q(pin_sync),
        .o_agree(pin_agree)
    );

    // Capture sequence: wait for the synchroniser to fill, then latch once settled
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_SETTLE:
            begin
                if (settle_r == `PSL_SETTLE_CYC)
                    state_nxt = ST_SAMPLE;
            end
            ST_SAMPLE:
            begin
                if (pin_agree)
                    state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                state_nxt = ST_RUN;
            end
            default:
            begin
                state_nxt = ST_SETTLE;
            end
        endcase
    end

    assign capture = state_r[1] & pin_agree;

    // Strap fields as seen by the synchroniser at the capture edge
    assign cap_speed = pin_sync[`PSL_PIN_SPEED];
    assign cap_iso = pin_sync[`PSL_PIN_ISO];
    assign cap_duplex = pin_sync[`PSL_PIN_DUPLEX];

    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r <= ST_SETTLE;
            settle_r <= 3'h0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r[0])
                settle_r <= settle_r + 3'h1;
        end
    end

    // Strap image, taken once and then frozen
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            strap_r <= `PSL_PU_MASK;
        else if (capture)
            strap_r <= pin_sync;
    end

    assign mode_code = {strap_r[`PSL_PIN_MODE2], strap_r[`PSL_PIN_MODE1],
        strap_r[`PSL_PIN_MODE0]};

    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_mgmt_addr <= 5'h01;
            o_bcast_zero_en <= 1'b1;
            o_mode_mii <= 1'b1;
            o_mode_b2b <= 1'b0;
            o_mode_reserved <= 1'b0;
            o_straps_done <= 1'b0;
        end
        else
        begin
            o_mgmt_addr <= mgmt_from_straps(strap_r);
            o_bcast_zero_en <= ~strap_r[`PSL_PIN_BCAST];
            {o_mode_reserved, o_mode_b2b, o_mode_mii} <= mode_class(mode_code);
            o_straps_done <= state_r[2];
        end
    end

    // Own address always hits; zero hits as broadcast unless broadcast-off
    assign o_mgmt_addr_hit = (i_mgmt_req_addr == o_mgmt_addr) ||
        ((i_mgmt_req_addr == 5'h00) && o_bcast_zero_en);

    // Shared pins: pulled inputs until latched, then driven outputs
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_strap_pin_out <= 10'h000;
            o_strap_pin_oe_n <= 10'h3FF;
            o_strap_pin_pu <= `PSL_PU_MASK;
            o_strap_pin_pd <= `PSL_PD_MASK;
        end
        else if (state_r[2])
        begin
            o_strap_pin_out <= i_strap_pin_func;
            o_strap_pin_oe_n <= 10'h000;
            o_strap_pin_pu <= `PSL_PU_MASK & KEEP_PU_MASK;
            o_strap_pin_pd <= 10'h000;
        end
    end

    // Avalon slave: every access answered on the second edge
    assign bus_req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = bus_req & ~ack_r;
    assign bus_wr = i_avs_write & ack_r;
    assign rsel = reg_sel(i_avs_address);
    assign wr_ctrl = bus_wr & rsel[0];
    assign wr_adv = bus_wr & rsel[1];

    // Read mux; unmapped offsets read zero
    always @*
    begin
        rdata_nxt = 32'h00000000;
        case (rsel)
            4'h1: rdata_nxt = ctrl_r;
            4'h2: rdata_nxt = adv_r;
            4'h4: rdata_nxt = {15'h0000, state_r[2], 6'h00, strap_r};
            4'h8: rdata_nxt = {24'h000000, o_mgmt_addr[2:0], o_bcast_zero_en,
                o_mode_reserved, mode_code};
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ack_r <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end
        else
        begin
            ack_r <= bus_req & ~ack_r;
            if (i_avs_read & ~ack_r)
                o_avs_readdata <= rdata_nxt;
        end
    end

    // Control and advertisement words: strap load wins over a software write
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_r <= `PSL_CTRL_RST;
            adv_r <= `PSL_ADV_RST;
        end
        else if (capture)
        begin
            ctrl_r <= 32'h00000000;
            ctrl_r[`PSL_CTRL_SPEED] <= cap_speed;
            ctrl_r[`PSL_CTRL_ISO] <= cap_iso;
            ctrl_r[`PSL_CTRL_DUPLEX] <= cap_duplex;
            adv_r <= adv_from_speed(cap_speed);
        end
        else if (bus_wr)
        begin
            if (wr_ctrl)
                ctrl_r <= be_merge(ctrl_r, i_avs_writedata, i_avs_byteenable,
                    `PSL_CTRL_WMASK);
            if (wr_adv)
                adv_r <= be_merge(adv_r, i_avs_writedata, i_avs_byteenable,
                    `PSL_ADV_WMASK);
        end
    end

    assign o_isolate = ctrl_r[`PSL_CTRL_ISO];
    assign o_speed100 = ctrl_r[`PSL_CTRL_SPEED];
    assign o_duplex_half = ctrl_r[`PSL_CTRL_DUPLEX];

    psl_mii u_mii (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_rx_nib(i_rx_nib),
        .i_rx_valid(i_rx_valid),
        .o_rx_taken(o_rx_taken),
        .o_mii_rxd(o_mii_rxd),
        .o_mii_rxdv(o_mii_rxdv),
        .o_mii_clk(mii_clk),
        .i_mii_txd(i_mii_txd),
        .i_mii_txen(i_mii_txen),
        .o_tx_nib(o_tx_nib),
        .o_tx_valid(o_tx_valid)
    );

    // Receive and transmit share one derived MII clock
    assign o_mii_rxc = mii_clk;
    assign o_mii_txc = mii_clk;
endmodule // psl_top

// File: bench/psl_top_sva.sv
// Port checker for the strap latch and MII pin block
`timescale 1ns/1ps
module psl_top_sva #(
    parameter [9:0] KEEP_PU_MASK = 10'h000
) (
    input logic i_clk,
    input logic i_rstn,
    input logic [9:0] o_strap_pin_oe_n,
    input logic [9:0] o_strap_pin_pu,
    input logic [9:0] o_strap_pin_pd,
    input logic o_straps_done,
    input logic [4:0] o_mgmt_addr,
    input logic o_bcast_zero_en,
    input logic [4:0] i_mgmt_req_addr,
    input logic o_mgmt_addr_hit,
    input logic o_mode_mii,
    input logic o_mode_b2b,
    input logic o_mode_reserved,
    input logic [3:0] o_mii_rxd,
    input logic o_mii_rxdv,
    input logic o_mii_rxc,
    input logic o_mii_txc,
    input logic [3:0] i_mii_txd,
    input logic i_mii_txen,
    input logic [3:0] o_tx_nib,
    input logic o_tx_valid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_tx_offer;
        !o_mii_txc && i_mii_txen;
    endsequence
    sequence s_tx_taken;
        o_tx_valid && o_tx_nib == $past(i_mii_txd);
    endsequence
    property p_pins_in;
        !o_straps_done |-> o_strap_pin_oe_n == 10'h3FF && o_strap_pin_pd == 10'h0FE
            && o_strap_pin_pu == 10'h301;
    endproperty
    a_pins_in: assert property (p_pins_in) else $error("pins not inputs before capture");
    property p_pins_out;
        o_straps_done |-> o_strap_pin_oe_n == 10'h000 && o_strap_pin_pd == 10'h000
            && o_strap_pin_pu == (10'h301 & KEEP_PU_MASK);
    endproperty
    a_pins_out: assert property (p_pins_out) else $error("pins wrong after capture");
    property p_hold;
        o_straps_done |=> o_straps_done && $stable(o_mgmt_addr) && $stable(o_bcast_zero_en);
    endproperty
    a_hold: assert property (p_hold) else $error("captured straps changed");
    property p_addr_hi;
        o_mgmt_addr[4:3] == 2'h0;
    endproperty
    a_addr_hi: assert property (p_addr_hi) else $error("address upper bits set");
    property p_hit;
        o_mgmt_addr_hit == (i_mgmt_req_addr == o_mgmt_addr
            || (i_mgmt_req_addr == 5'h00 && o_bcast_zero_en));
    endproperty
    a_hit: assert property (p_hit) else $error("address match wrong");
    property p_mode;
        $onehot({o_mode_mii, o_mode_b2b, o_mode_reserved});
    endproperty
    a_mode: assert property (p_mode) else $error("mode decode not one-hot");
    property p_rx_zero;
        !o_mii_rxdv |-> o_mii_rxd == 4'h0;
    endproperty
    a_rx_zero: assert property (p_rx_zero) else $error("receive nibble not zero");
    property p_rx_launch;
        !$fell(o_mii_rxc) |-> $stable(o_mii_rxd) && $stable(o_mii_rxdv);
    endproperty
    a_rx_launch: assert property (p_rx_launch) else $error("receive off clock");
    property p_tx_take;
        s_tx_offer |=> s_tx_taken;
    endproperty
    a_tx_take: assert property (p_tx_take) else $error("transmit nibble not taken");
    property p_tx_skip;
        !o_mii_txc && !i_mii_txen |=> !o_tx_valid;
    endproperty
    a_tx_skip: assert property (p_tx_skip) else $error("nibble taken without enable");
    property p_tx_pulse;
        o_tx_valid |=> !o_tx_valid;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("transmit valid too long");
endmodule // psl_top_sva

bind psl_top psl_top_sva #(.KEEP_PU_MASK(KEEP_PU_MASK)) sva_u (
    .i_clk(i_clk), .i_rstn(i_rstn), .o_strap_pin_oe_n(o_strap_pin_oe_n),
    .o_strap_pin_pu(o_strap_pin_pu), .o_strap_pin_pd(o_strap_pin_pd),
    .o_straps_done(o_straps_done), .o_mgmt_addr(o_mgmt_addr),
    .o_bcast_zero_en(o_bcast_zero_en), .i_mgmt_req_addr(i_mgmt_req_addr),
    .o_mgmt_addr_hit(o_mgmt_addr_hit), .o_mode_mii(o_mode_mii), .o_mode_b2b(o_mode_b2b),
    .o_mode_reserved(o_mode_reserved), .o_mii_rxd(o_mii_rxd), .o_mii_rxdv(o_mii_rxdv),
    .o_mii_rxc(o_mii_rxc), .o_mii_txc(o_mii_txc), .i_mii_txd(i_mii_txd),
    .i_mii_txen(i_mii_txen), .o_tx_nib(o_tx_nib), .o_tx_valid(o_tx_valid)
);

// File: bench/psl_mac_model.sv
// MAC on the MII plus the board strap resistors
`timescale 1ns/1ps
module psl_mac_model (
    input logic i_clk,
    input logic i_send,
    input logic [9:0] i_board,
    input logic [9:0] i_out,
    input logic [9:0] i_oe_n,
    output logic [9:0] o_pin,
    input logic i_txc,
    output logic [3:0] o_txd,
    output logic o_txen,
    input logic i_rxc,
    input logic [3:0] i_rxd,
    input logic i_rxdv
);
    logic [3:0] nib;
    logic [3:0] sent_q[$];
    logic [3:0] rx_q[$];
    // Driven level where enabled, else the board resistor
    assign o_pin = (i_out & ~i_oe_n) | (i_board & i_oe_n);
    initial
    begin
        o_txd = 4'h0;
        o_txen = 1'b0;
        nib = 4'h0;
    end
    // New nibble while the transmit clock falls, one idle slot in four
    always @(posedge i_clk)
    begin
        if (i_txc)
        begin
            nib <= nib + 4'h1;
            if (i_send && nib[1:0] != 2'h3)
            begin
                o_txen <= 1'b1;
                o_txd <= nib;
                sent_q.push_back(nib);
            end
            else
            begin
                o_txen <= 1'b0;
                o_txd <= ~o_txd;
            end
        end
    end
    always @(posedge i_rxc)
        if (i_rxdv)
            rx_q.push_back(i_rxd);
endmodule // psl_mac_model

// File: bench/psl_top_test.sv
// Self-checking bench for the strap latch and MII pin block
`timescale 1ns/1ps
module psl_top_test;
    logic i_clk, i_rstn, i_avs_read, i_avs_write, i_rx_valid, i_mii_txen, send;
    logic [9:0] i_strap_pin_in, i_strap_pin_func, board, p;
    logic [4:0] i_mgmt_req_addr;
    logic [3:0] i_avs_address, i_avs_byteenable, i_rx_nib, i_mii_txd, k;
    logic [31:0] i_avs_writedata, rd;
    wire [9:0] o_strap_pin_out, o_strap_pin_oe_n, o_strap_pin_pu, o_strap_pin_pd;
    wire [4:0] o_mgmt_addr;
    wire [3:0] o_mii_rxd, o_tx_nib;
    wire [31:0] o_avs_readdata;
    wire o_straps_done, o_bcast_zero_en, o_mgmt_addr_hit, o_mode_mii, o_mode_b2b;
    wire o_mode_reserved, o_isolate, o_speed100, o_duplex_half, o_avs_waitrequest;
    wire o_rx_taken, o_mii_rxdv, o_mii_rxc, o_mii_txc, o_tx_valid;
    logic [9:0] pats [0:4] = '{10'h301, 10'h068, 10'h097, 10'h2F8, 10'h10A};
    logic [3:0] tx_q[$], exp_q[$];
    integer fails = 0, check_count = 0, n, j;
    psl_top #(.KEEP_PU_MASK(10'h301)) dut_u (
        .i_clk(i_clk), .i_rstn(i_rstn),
        .i_strap_pin_in(i_strap_pin_in), .i_strap_pin_func(i_strap_pin_func),
        .o_strap_pin_out(o_strap_pin_out), .o_strap_pin_oe_n(o_strap_pin_oe_n),
        .o_strap_pin_pu(o_strap_pin_pu), .o_strap_pin_pd(o_strap_pin_pd),
        .o_straps_done(o_straps_done), .o_mgmt_addr(o_mgmt_addr),
        .o_bcast_zero_en(o_bcast_zero_en), .i_mgmt_req_addr(i_mgmt_req_addr),
        .o_mgmt_addr_hit(o_mgmt_addr_hit), .o_mode_mii(o_mode_mii),
        .o_mode_b2b(o_mode_b2b), .o_mode_reserved(o_mode_reserved),
        .o_isolate(o_isolate), .o_speed100(o_speed100), .o_duplex_half(o_duplex_half),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_rx_nib(i_rx_nib), .i_rx_valid(i_rx_valid), .o_rx_taken(o_rx_taken),
        .o_mii_rxd(o_mii_rxd), .o_mii_rxdv(o_mii_rxdv), .o_mii_rxc(o_mii_rxc),
        .o_mii_txc(o_mii_txc), .i_mii_txd(i_mii_txd), .i_mii_txen(i_mii_txen),
        .o_tx_nib(o_tx_nib), .o_tx_valid(o_tx_valid)
    );
    psl_mac_model mac_u (
        .i_clk(i_clk),
        .i_send(send),
        .i_board(board),
        .i_out(o_strap_pin_out),
        .i_oe_n(o_strap_pin_oe_n),
        .o_pin(i_strap_pin_in),
        .i_txc(o_mii_txc),
        .o_txd(i_mii_txd),
        .o_txen(i_mii_txen),
        .i_rxc(o_mii_rxc),
        .i_rxd(o_mii_rxd),
        .i_rxdv(o_mii_rxdv)
    );
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon access; read data lands in rd
    task bus(input logic wr, input logic [3:0] ad, input logic [31:0] dat, input logic [3:0] ben);
        integer c;
        @(posedge i_clk);
        i_avs_address <= ad;
        i_avs_writedata <= dat;
        i_avs_byteenable <= ben;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        c = 0;
        do
        begin
            @(posedge i_clk);
            c = c + 1;
        end
        while (o_avs_waitrequest !== 1'b0 && c < 20);
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        if (o_avs_waitrequest !== 1'b0)
        begin
            fails = fails + 1;
            report_and_stop;
        end
    endtask
    initial
    begin
        i_rstn = 1'b0;
        {i_avs_read, i_avs_write, i_rx_valid, send} = 4'h0;
        {i_avs_address, i_rx_nib, k} = 12'h000;
        i_avs_byteenable = 4'hF;
        i_avs_writedata = 32'h0;
        i_mgmt_req_addr = 5'h00;
        i_strap_pin_func = 10'h155;
        board = 10'h301;
        for (j = 0; j < 5; j = j + 1)
        begin
            p = pats[j];
            @(posedge i_clk);
            board <= p;
            i_mgmt_req_addr <= 5'h00;
            i_rstn <= 1'b0;
            repeat (20) @(posedge i_clk);
            chk({o_strap_pin_oe_n, o_strap_pin_pu, o_strap_pin_pd}, {10'h3FF, 10'h301, 10'h0FE});
            chk(o_mgmt_addr, 5'h01);
            i_rstn <= 1'b1;
            for (n = 0; n < 50 && o_straps_done !== 1'b1; n = n + 1)
                @(posedge i_clk);
            chk(o_straps_done, 1'b1);
            if (o_straps_done !== 1'b1)
                report_and_stop;
            chk(o_mgmt_addr, {2'h0, p[2:0]});
            chk(o_bcast_zero_en, !p[3]);
            chk(o_mgmt_addr_hit, p[2:0] == 3'h0 || !p[3]);
            chk({o_mode_mii, o_mode_b2b, o_mode_reserved},
                {p[6:4] == 3'h0, p[6:4] == 3'h6, p[6:4] != 3'h0 && p[6:4] != 3'h6});
            chk({o_isolate, o_speed100, o_duplex_half}, {p[7], p[8], p[9]});
            chk({o_strap_pin_oe_n, o_strap_pin_pu, o_strap_pin_pd}, {10'h000, 10'h301, 10'h000});
            chk(o_strap_pin_out, i_strap_pin_func);
            bus(1'b0, 4'h4, 32'h0, 4'hF);
            chk(rd, p[8] ? 32'h1E0 : 32'h060);
            bus(1'b0, 4'h0, 32'h0, 4'hF);
            chk(rd, {18'h0, p[8], 2'h0, p[7], 1'h0, p[9], 8'h0});
            bus(1'b0, 4'h8, 32'h0, 4'hF);
            chk(rd, {15'h0, 1'b1, 6'h0, p});
            bus(1'b0, 4'hC, 32'h0, 4'hF);
            chk(rd, {24'h0, p[2:0], !p[3], p[6:4] != 3'h0 && p[6:4] != 3'h6, p[6:4]});
            i_mgmt_req_addr <= {2'h0, p[2:0]};
            i_strap_pin_func <= ~i_strap_pin_func;
            board <= ~p;
            repeat (10) @(posedge i_clk);
            chk({o_mgmt_addr, o_isolate, o_strap_pin_out}, {2'h0, p[2:0], p[7], i_strap_pin_func});
            chk(o_mgmt_addr_hit, 1'b1);
        end
        bus(1'b1, 4'h0, 32'hFFFFFFFF, 4'h2);
        bus(1'b1, 4'h0, 32'h0, 4'h1);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(rd, 32'h2500);
        bus(1'b1, 4'h8, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, 4'h8, 32'h0, 4'hF);
        chk(rd, {15'h0, 1'b1, 6'h0, p});
        bus(1'b0, 4'h2, 32'h0, 4'hF);
        chk(rd, 32'h0);
        send <= 1'b1;
        for (n = 0; n < 80; n = n + 1)
        begin
            @(posedge i_clk);
            if (o_tx_valid === 1'b1)
                tx_q.push_back(o_tx_nib);
            if (o_rx_taken === 1'b1)
            begin
                if (i_rx_valid)
                    exp_q.push_back(i_rx_nib);
                i_rx_nib <= k;
                i_rx_valid <= k[0] && n < 60;
                k = k + 4'h3;
            end
            if (n == 60)
                send <= 1'b0;
        end
        chk(tx_q.size(), mac_u.sent_q.size());
        foreach (tx_q[i])
            chk(tx_q[i], mac_u.sent_q[i]);
        chk(mac_u.rx_q.size(), exp_q.size());
        foreach (exp_q[i])
            chk(mac_u.rx_q[i], exp_q[i]);
        report_and_stop;
    end
endmodule // psl_top_test
